// ==== scm_regs.vh ====
// Purpose: Register map, field positions and reset values of the clock and mode controller
// Assumes: Byte-addressed classic Wishbone, 32-bit data, registers in the low byte
// Notes:   Offsets are byte addresses
`ifndef SCM_REGS_VH
`define SCM_REGS_VH

`define SCM_ADDR_SYSCLK      8'h00
`define SCM_ADDR_FASTOSC     8'h04
`define SCM_ADDR_STATUS      8'h08
`define SCM_ADDR_WAKE_EN     8'h0c

`define SCM_SCC_SEL_HI       7
`define SCM_SCC_SEL_LO       5
`define SCM_SCC_FAST_SB      1
`define SCM_SCC_SLOW_SB      0
`define SCM_SCC_RESET        8'h00

`define SCM_FOC_STABLE       1
`define SCM_FOC_ENABLE       0
`define SCM_FOC_EN_RESET     1'b1

`define SCM_ST_TIMEOUT       4
`define SCM_ST_PDOWN         3
`define SCM_ST_STANDBY       2
`define SCM_ST_SLOW_ACT      1
`define SCM_ST_FAST_ACT      0

`define SCM_SEL_SLOW         3'h7
`define SCM_SEL_FAST         3'h0

`endif

// ==== scm_clk_gen.v ====
// Purpose: Glitch-free system clock enable generator (fast/divided or slow source)
// Assumes: Fast and slow oscillators appear as enable ticks on core_clk
// Notes:   Divider restarts only at a period boundary so no short pulse appears
`timescale 1ns/1ps
`default_nettype none
`include "scm_regs.vh"

module scm_clk_gen #(
  parameter DIV_W = 6
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       resetn,
  // Sources
  input  wire       fastTick,
  input  wire       slowTick,
  input  wire [2:0] clockSelect,
  input  wire       sysRun,
  // Output
  output reg        sysTick_reg
);

  reg  [DIV_W-1:0] divCnt_reg;
  reg  [2:0]       selActive_reg;
  wire [DIV_W-1:0] divMask;
  wire             fastBoundary;

  assign divMask      = (selActive_reg == `SCM_SEL_SLOW) ? {DIV_W{1'b0}}
                      : ((({{(DIV_W-1){1'b0}},1'b1}) << selActive_reg) - 1'b1);
  assign fastBoundary = fastTick && ((divCnt_reg & divMask) == divMask);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_reg    <= {DIV_W{1'b0}};
      selActive_reg <= `SCM_SEL_FAST;
      sysTick_reg   <= 1'b0;
    end else begin
      sysTick_reg <= 1'b0;
      if (selActive_reg == `SCM_SEL_SLOW) begin
        if (slowTick) begin
          sysTick_reg   <= sysRun;
          selActive_reg <= clockSelect;
          divCnt_reg    <= {DIV_W{1'b0}};
        end
      end else if (fastTick) begin
        divCnt_reg <= divCnt_reg + 1'b1;
        if (fastBoundary) begin
          sysTick_reg   <= sysRun;
          divCnt_reg    <= {DIV_W{1'b0}};
          selActive_reg <= clockSelect;
        end
      end
    end
  end

endmodule // scm_clk_gen
`default_nettype wire

// ==== scm_sysclk_ctrl.v ====
// Purpose: System clock select, standby mode sequencing and wake-up control
// Assumes: Oscillator ticks arrive on core_clk; port pins and slow stable flag are synchronised here
// Notes:   Registers sit in the low byte of 32-bit Wishbone words
//
// Functional notes
// - Select codes 0..6 give fast clock divided by 1..64; code 7 slow clock.
// - Fast standby bit decides whether fast oscillator runs after stop.
// - Slow standby bit decides whether slow oscillator runs after stop.
// - Clock control bits 4..2 read zero; implemented bits reset cleared.
// - Enabling fast oscillator clears stable flag, sets it once stable.
// - Fast oscillator enable bit 0, resets to one.
// - Fast oscillator register bits 7..2 read zero; stable flag resets zero.
// - Stop with both standby bits zero: deep standby, system clock stops.
// - Fast bit zero, slow bit one: fast clock stops, slow runs.
// - Both standby bits one: both clocks run, execution halts.
// - Fast bit one, slow bit zero: fast runs, slow clock stops.
// - Standby entry sets power-down flag and clears timeout flag.
// - Standby entry clears watchdog; it resumes only if enabled.
// - Switch to slow clock completes only after slow oscillator stable.
// - Software polls stable flag when returning to fast clock.
// - Wake on port A falling edge, interrupt or watchdog overflow.
// - Stop sets power-down flag; only power-up or clear-watchdog clears it.
// - Watchdog overflow in standby wakes, sets timeout, resets PC and SP.
// - Per-pin port A wake enable; resume after the stop instruction.
// - Disabled interrupt or full stack resumes after stop, request pending.
// - Interrupt already pending at standby entry cannot wake.
// - Fast clock from fast RC oscillator, slow from slow RC oscillator.
// - Deep standby keeps slow oscillator only if watchdog enabled.
`timescale 1ns/1ps
`default_nettype none
`include "scm_regs.vh"

module scm_sysclk_ctrl #(
  parameter PORT_W     = 8,
  parameter STABLE_CNT = 16,
  parameter STAB_W     = 5
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              resetn,
  // Wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  // Oscillators
  input  wire              fastRcTick,
  input  wire              slowRcTick,
  input  wire              slowRcStable,
  output wire              fastRcRun,
  output wire              slowRcRun,
  output wire              sysClkTick,
  // CPU core
  input  wire              stopInstr,
  input  wire              clrWdtInstr,
  output wire              cpuHalted,
  output reg               wakeResume,
  output reg               wakeIntService,
  output reg               pcSpReset,
  // Interrupt logic
  input  wire              intRequest,
  input  wire              intEnabled,
  input  wire              stackFull,
  // Watchdog
  input  wire              wdtEnabled,
  input  wire              wdtOverflow,
  output reg               wdtClear,
  output wire              wdtRun,
  // Port A
  input  wire [PORT_W-1:0] portAPin
);

  localparam ST_RUN     = 2'b01;
  localparam ST_STANDBY = 2'b10;

  reg  [2:0]        clockSelect_reg;
  reg               fastSbEn_reg;
  reg               slowSbEn_reg;
  reg               fastEn_reg;
  reg               fastStable_reg;
  reg  [STAB_W-1:0] stabCnt_reg;
  reg               powerDown_reg;
  reg               timeout_reg;
  reg  [PORT_W-1:0] wakeEn_reg;
  reg  [PORT_W-1:0] pinMeta_reg;
  reg  [PORT_W-1:0] pinSync_reg;
  reg  [PORT_W-1:0] pinPrev_reg;
  reg               intMasked_reg;
  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg               ack_reg;
  reg  [2:0]        slowSelPend_reg;
  reg               slowStMeta_reg;
  reg               slowStSync_reg;

  wire             wbReq;
  wire             wbWr;
  wire             inStandby;
  wire             portWake;
  wire             intWake;
  wire             wakeAny;
  wire             stopTake;
  wire [PORT_W-1:0] pinFall;
  wire [2:0]       effSelect;

  assign wbReq = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wbWr  = wbReq && wb_we_i && wb_sel_i[0];
  assign wb_ack_o = ack_reg;
  assign inStandby = (state_reg == ST_STANDBY);
  assign stopTake  = (state_reg == ST_RUN) && stopInstr;

  // Port A edges, synchronised first
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : gPin
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          pinMeta_reg[gi] <= 1'b1;
          pinSync_reg[gi] <= 1'b1;
          pinPrev_reg[gi] <= 1'b1;
        end else begin
          pinMeta_reg[gi] <= portAPin[gi];
          pinSync_reg[gi] <= pinMeta_reg[gi];
          pinPrev_reg[gi] <= pinSync_reg[gi];
        end
      end
      assign pinFall[gi] = wakeEn_reg[gi] && pinPrev_reg[gi] && !pinSync_reg[gi];
    end
  endgenerate

  assign portWake = |pinFall;
  assign intWake  = intRequest && !intMasked_reg;
  assign wakeAny  = portWake || intWake || wdtOverflow;

  // Oscillator run controls per mode
  assign fastRcRun = inStandby ? fastSbEn_reg : fastEn_reg;
  assign slowRcRun = inStandby ? (slowSbEn_reg ||
                                  (!fastSbEn_reg && wdtEnabled)) : 1'b1;
  assign cpuHalted = inStandby;
  assign wdtRun    = wdtEnabled;

  // Slow select held back until the slow oscillator is stable
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slowStMeta_reg  <= 1'b0;
      slowStSync_reg  <= 1'b0;
      slowSelPend_reg <= `SCM_SEL_FAST;
    end else begin
      slowStMeta_reg <= slowRcStable;
      slowStSync_reg <= slowStMeta_reg;
      if (clockSelect_reg != `SCM_SEL_SLOW || slowStSync_reg)
        slowSelPend_reg <= clockSelect_reg;
    end
  end
  assign effSelect = slowSelPend_reg;

  scm_clk_gen #(
    .DIV_W (6)
  ) uClkGen (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .fastTick    (fastRcTick && fastRcRun),
    .slowTick    (slowRcTick && slowRcRun),
    .clockSelect (effSelect),
    .sysRun      (!inStandby),
    .sysTick_reg (sysClkTick)
  );

  // Mode sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:     if (stopInstr) state_next = ST_STANDBY;
      ST_STANDBY: if (wakeAny) state_next = ST_RUN;
      default:    state_next = ST_RUN;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_RUN;
      intMasked_reg  <= 1'b0;
      wakeResume     <= 1'b0;
      wakeIntService <= 1'b0;
      pcSpReset      <= 1'b0;
      wdtClear       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      wakeResume     <= 1'b0;
      wakeIntService <= 1'b0;
      pcSpReset      <= 1'b0;
      wdtClear       <= stopTake || clrWdtInstr;
      if (stopTake)
        intMasked_reg <= intRequest;
      if (inStandby && wakeAny) begin
        if (wdtOverflow)
          pcSpReset <= 1'b1;
        else if (intWake && intEnabled && !stackFull)
          wakeIntService <= 1'b1;
        else
          wakeResume <= 1'b1;
      end
    end
  end

  // Registers and status flags
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clockSelect_reg <= `SCM_SEL_FAST;
      fastSbEn_reg    <= 1'b0;
      slowSbEn_reg    <= 1'b0;
      fastEn_reg      <= `SCM_FOC_EN_RESET;
      fastStable_reg  <= 1'b0;
      stabCnt_reg     <= {STAB_W{1'b0}};
      powerDown_reg   <= 1'b0;
      timeout_reg     <= 1'b0;
      wakeEn_reg      <= {PORT_W{1'b0}};
      ack_reg         <= 1'b0;
    end else begin
      ack_reg <= wbReq;
      if (wbWr && wb_adr_i == `SCM_ADDR_SYSCLK) begin
        clockSelect_reg <= wb_dat_i[`SCM_SCC_SEL_HI:`SCM_SCC_SEL_LO];
        fastSbEn_reg    <= wb_dat_i[`SCM_SCC_FAST_SB];
        slowSbEn_reg    <= wb_dat_i[`SCM_SCC_SLOW_SB];
      end
      if (wbWr && wb_adr_i == `SCM_ADDR_WAKE_EN)
        wakeEn_reg <= wb_dat_i[PORT_W-1:0];
      // Stability counter runs on oscillator ticks while it is running
      if (wbWr && wb_adr_i == `SCM_ADDR_FASTOSC) begin
        fastEn_reg <= wb_dat_i[`SCM_FOC_ENABLE];
        if (wb_dat_i[`SCM_FOC_ENABLE] && !fastEn_reg) begin
          fastStable_reg <= 1'b0;
          stabCnt_reg    <= {STAB_W{1'b0}};
        end
      end else if (!fastRcRun) begin
        fastStable_reg <= 1'b0;
        stabCnt_reg    <= {STAB_W{1'b0}};
      end else if (fastRcTick && !fastStable_reg) begin
        if (stabCnt_reg == STABLE_CNT[STAB_W-1:0] - 1'b1)
          fastStable_reg <= 1'b1;
        stabCnt_reg <= stabCnt_reg + 1'b1;
      end
      // Set wins over the clear-watchdog clear
      if (stopTake)
        powerDown_reg <= 1'b1;
      else if (clrWdtInstr)
        powerDown_reg <= 1'b0;
      if (inStandby && wdtOverflow)
        timeout_reg <= 1'b1;
      else if (stopTake)
        timeout_reg <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    wb_dat_o = 32'h0000_0000;
    case (wb_adr_i)
      `SCM_ADDR_SYSCLK: begin
        wb_dat_o[`SCM_SCC_SEL_HI:`SCM_SCC_SEL_LO] = clockSelect_reg;
        wb_dat_o[`SCM_SCC_FAST_SB] = fastSbEn_reg;
        wb_dat_o[`SCM_SCC_SLOW_SB] = slowSbEn_reg;
      end
      `SCM_ADDR_FASTOSC: begin
        wb_dat_o[`SCM_FOC_STABLE] = fastStable_reg;
        wb_dat_o[`SCM_FOC_ENABLE] = fastEn_reg;
      end
      `SCM_ADDR_STATUS: begin
        wb_dat_o[`SCM_ST_TIMEOUT]  = timeout_reg;
        wb_dat_o[`SCM_ST_PDOWN]    = powerDown_reg;
        wb_dat_o[`SCM_ST_STANDBY]  = inStandby;
        wb_dat_o[`SCM_ST_SLOW_ACT] = (slowSelPend_reg == `SCM_SEL_SLOW);
        wb_dat_o[`SCM_ST_FAST_ACT] = fastRcRun;
      end
      `SCM_ADDR_WAKE_EN: wb_dat_o[PORT_W-1:0] = wakeEn_reg;
      default: wb_dat_o = 32'h0000_0000;
    endcase
  end

endmodule // scm_sysclk_ctrl
`default_nettype wire

// ==== scm_osc_model.sv ====
// Purpose: Oscillator model that ticks only while a run is requested
// Assumes: Both oscillators tick on core_clk
// Notes:   Slow side reports stable with its first tick after it starts, so slow select waits
`timescale 1ns/1ps
`default_nettype none
module scm_osc_model #(
  parameter int FP = 2,
  parameter int SP = 40
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Run requests and ticks
  input  wire logic fastRun,
  input  wire logic slowRun,
  output var  logic fastTick,
  output var  logic slowTick,
  output var  logic slowStable
);
  int fc;
  int sc;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fc <= 0;
      sc <= 0;
      fastTick <= 1'b0;
      slowTick <= 1'b0;
      slowStable <= 1'b0;
    end else begin
      fc <= (fc == FP - 1) ? 0 : fc + 1;
      sc <= (sc == SP - 1) ? 0 : sc + 1;
      fastTick <= fastRun && fc == FP - 1;
      slowTick <= slowRun && sc == SP - 1;
      slowStable <= slowRun && (slowStable || sc == SP - 1);
    end
  end
endmodule // scm_osc_model
`default_nettype wire

// ==== scm_monitor.sv ====
// Purpose: Port-level checks of the clock and mode controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the design from the bench
`timescale 1ns/1ps
`default_nettype none
module scm_monitor (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core and watchdog
  input wire logic stopInstr,
  input wire logic cpuHalted,
  input wire logic sysClkTick,
  input wire logic wdtEnabled,
  input wire logic wdtOverflow,
  input wire logic wdtClear,
  input wire logic wdtRun,
  // Wake pulses
  input wire logic wakeResume,
  input wire logic wakeIntService,
  input wire logic pcSpReset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic [2:0] wk = {pcSpReset, wakeIntService, wakeResume};
  property p_ackNext;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
  property p_stop;
    stopInstr && !cpuHalted |=> cpuHalted && wdtClear;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  // Checked one cycle in, as the stopping edge may still carry a tick
  property p_noTick;
    cpuHalted && $past(cpuHalted) |-> !sysClkTick;
  endproperty
  a_noTick: assert property (p_noTick) else $error("tick in standby");
  property p_wdtRun;
    wdtRun == wdtEnabled;
  endproperty
  a_wdtRun: assert property (p_wdtRun) else $error("watchdog run wrong");
  property p_ovf;
    cpuHalted && wdtOverflow |=> pcSpReset && !cpuHalted;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wake wrong");
  property p_oneKind;
    $onehot0(wk);
  endproperty
  a_oneKind: assert property (p_oneKind) else $error("two wake kinds");
  property p_wakeCause;
    $fell(cpuHalted) |-> wk != 3'b000;
  endproperty
  a_wakeCause: assert property (p_wakeCause) else $error("wake without kind");
  c_stop: cover property (stopInstr && !cpuHalted);
  c_ovf: cover property (pcSpReset);
  c_int: cover property (wakeIntService);
endmodule // scm_monitor
`default_nettype wire

// ==== test_scm_sysclk_ctrl.sv ====
// Purpose: Self-checking bench for the clock select and standby controller
// Assumes: Oscillator model ticks on core_clk
// Notes:   Random values come from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
`include "scm_regs.vh"
module test_scm_sysclk_ctrl;
  localparam int FP = 2;
  localparam int SP = 40;
  localparam int STABLE = 16;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, wbWe = 1'b0, ack;
  logic [7:0]  adr = 8'h00, rd, portA = 8'hff;
  logic [31:0] datI = 32'h0, datO, rng = 32'h34a8;
  logic        fTick, sTick, sStable, fRun, sRun, sysTick, halted, wRes, wInt, pcSp, wdtClr, wdtRun;
  logic        stop = 1'b0, clrWdt = 1'b0, intReq = 1'b0, intEn = 1'b0, stackFull = 1'b0;
  logic        wdtEn = 1'b1, wdtOvf = 1'b0;
  logic [2:0]  k;
  int          checks = 0, miscompares = 0, g;
  always #4 core_clk = ~core_clk;
  scm_osc_model #(.FP(FP), .SP(SP)) u_osc (.core_clk(core_clk), .resetn(resetn), .fastRun(fRun),
    .slowRun(sRun), .fastTick(fTick), .slowTick(sTick), .slowStable(sStable));
  scm_sysclk_ctrl #(.PORT_W(8), .STABLE_CNT(STABLE), .STAB_W(5)) u_dut (.core_clk(core_clk),
    .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .fastRcTick(fTick),
    .slowRcTick(sTick), .slowRcStable(sStable), .fastRcRun(fRun), .slowRcRun(sRun),
    .sysClkTick(sysTick), .stopInstr(stop), .clrWdtInstr(clrWdt), .cpuHalted(halted),
    .wakeResume(wRes), .wakeIntService(wInt), .pcSpReset(pcSp), .intRequest(intReq),
    .intEnabled(intEn), .stackFull(stackFull), .wdtEnabled(wdtEn), .wdtOverflow(wdtOvf),
    .wdtClear(wdtClr), .wdtRun(wdtRun), .portAPin(portA));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic int period(input int c);
    return (c == 7) ? SP : (FP << c);
  endfunction
  function automatic logic [2:0] wakeKind(input int sb);
    return (sb == 3) ? 3'b100 : (sb == 1) ? 3'b010 : 3'b001;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= we;
    adr <= a;
    datI <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      miscompares++;
    rd = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // Sampled just after the edge so the registered tick has settled
  task automatic tick();
    g = 0;
    do begin
      @(posedge core_clk);
      #1;
      g++;
    end while (sysTick !== 1'b1 && g < 1000);
  endtask
  task automatic halt();
    stop <= 1'b1;
    @(posedge core_clk);
    stop <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wake();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      wdtOvf <= 1'b0;
      #1;
      n++;
    end while (halted !== 1'b0 && n < 40);
    k = {pcSp, wInt, wRes};
    @(posedge core_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    wb(0, `SCM_ADDR_SYSCLK, 0);
    check("sysclk", rd, 8'h00);
    wb(0, `SCM_ADDR_FASTOSC, 0);
    check("fastosc", rd, 8'h01);
    for (int c = 0; c < 8; c++) begin
      g = rnd();
      wb(1, `SCM_ADDR_SYSCLK, {c[2:0], g[4:0]});
      wb(0, `SCM_ADDR_SYSCLK, 0);
      check("select", rd, {c[2:0], 3'b000, g[1:0]});
      repeat (3) tick();
      check("period", g, period(c));
      @(posedge core_clk);
    end
    // Slow clock is selected here, so the fast oscillator may be stopped
    wb(1, `SCM_ADDR_FASTOSC, 8'h00);
    wb(0, `SCM_ADDR_FASTOSC, 0);
    check("fast off", {rd, fRun}, 9'h000);
    wb(1, `SCM_ADDR_FASTOSC, 8'hfd);
    wb(0, `SCM_ADDR_FASTOSC, 0);
    check("unstable", rd, 8'h01);
    repeat (STABLE * FP + 20) @(posedge core_clk);
    wb(0, `SCM_ADDR_FASTOSC, 0);
    check("stable", rd, 8'h03);
    wb(1, 8'h10, 8'h5a);
    wb(0, 8'h10, 0);
    check("unmapped", rd, 8'h00);
    for (int sb = 0; sb < 4; sb++) begin
      g = rnd();
      wdtEn <= (sb == 3) | g[5];
      wb(1, `SCM_ADDR_WAKE_EN, 8'h01 << g[2:0]);
      wb(1, `SCM_ADDR_SYSCLK, sb[7:0]);
      halt();
      check("halted", halted, 1);
      check("fast run", fRun, sb[1]);
      check("slow run", sRun, sb[0] | (sb == 0 && wdtEn));
      wb(0, `SCM_ADDR_STATUS, 0);
      check("flags stop", rd[4:3], 2'b01);
      case (sb)
        0: portA[g[2:0]] <= 1'b0;
        1: begin intReq <= 1'b1; intEn <= 1'b1; stackFull <= 1'b0; end
        2: begin intReq <= 1'b1; intEn <= 1'b1; stackFull <= 1'b1; end
        default: wdtOvf <= 1'b1;
      endcase
      wake();
      check("wake kind", k, wakeKind(sb));
      portA <= 8'hff;
      intReq <= 1'b0;
      wb(0, `SCM_ADDR_STATUS, 0);
      check("flags wake", rd[4:3], {sb == 3, 1'b1});
      clrWdt <= 1'b1;
      @(posedge core_clk);
      clrWdt <= 1'b0;
      wb(0, `SCM_ADDR_STATUS, 0);
      check("pdown clr", rd[3], 1'b0);
    end
    wb(1, `SCM_ADDR_WAKE_EN, 8'hff);
    intReq <= 1'b1;
    halt();
    repeat (10) @(posedge core_clk);
    check("pending int", halted, 1);
    portA[0] <= 1'b0;
    wake();
    check("port wake", k, 3'b001);
    stop_test();
  end
endmodule // test_scm_sysclk_ctrl
bind scm_sysclk_ctrl scm_monitor u_mon (.core_clk(core_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stopInstr(stopInstr),
  .cpuHalted(cpuHalted), .sysClkTick(sysClkTick), .wdtEnabled(wdtEnabled),
  .wdtOverflow(wdtOverflow), .wdtClear(wdtClear), .wdtRun(wdtRun), .wakeResume(wakeResume),
  .wakeIntService(wakeIntService), .pcSpReset(pcSpReset));
`default_nettype wire
